// ---- ivp_pkg.sv ----
package ivp_pkg;

  // Register byte addresses on the bus
  localparam logic [31:0] IVP_CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] IVP_STAT_ADDR   = 32'h0000_0004;
  localparam logic [31:0] IVP_ADDR_MASK   = 32'h0000_00fc;

  // Control register layout
  localparam int          IVP_VCE_BIT     = 0;
  localparam int          IVP_VSEL_BIT    = 1;
  localparam int          IVP_EXT0_BIT    = 6;
  localparam int          IVP_EXT1_BIT    = 7;
  localparam logic [7:0]  IVP_CTRL_RESET  = 8'h00;

  // Status register layout
  localparam int          IVP_ST_BLOCK    = 0;
  localparam int          IVP_ST_HOLD     = 1;
  localparam int          IVP_ST_LOCK     = 2;
  localparam int          IVP_ST_CNT_LSB  = 4;
  localparam int          IVP_ST_BOOT_LSB = 16;

  // Change window length in clock cycles
  localparam logic [2:0]  IVP_WINDOW_CYC  = 3'h4;

  // AHB encodings
  localparam logic [1:0]  IVP_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  IVP_HTRANS_SEQ  = 2'h3;

  // Program flash word addresses
  localparam int          IVP_PC_W        = 12;
  localparam int          IVP_VEC_W       = 5;
  localparam logic [11:0] IVP_APP_START   = 12'h000;
  localparam logic [11:0] IVP_BOOT_2K     = 12'h0c00;
  localparam logic [11:0] IVP_BOOT_1K     = 12'h0e00;
  localparam logic [11:0] IVP_BOOT_512    = 12'h0f00;
  localparam logic [11:0] IVP_BOOT_256    = 12'h0f80;
  localparam logic [4:0]  IVP_VEC_LAST    = 5'h12;

  typedef enum logic [2:0] {
    IVP_IDLE = 3'b001,
    IVP_OPEN = 3'b010,
    IVP_HOLD = 3'b100
  } ivp_state_t;

  // Start of the boot section for a boot size setting
  function automatic logic [11:0] ivp_boot_start(input logic [1:0] sz);
    case (sz)
      2'h0:    ivp_boot_start = IVP_BOOT_2K;
      2'h1:    ivp_boot_start = IVP_BOOT_1K;
      2'h2:    ivp_boot_start = IVP_BOOT_512;
      default: ivp_boot_start = IVP_BOOT_256;
    endcase
  endfunction : ivp_boot_start

endpackage : ivp_pkg

// ---- ivp_ahb_slave.sv ----
`timescale 1ns/1ps
module ivp_ahb_slave
  import ivp_pkg::*;
(
  input  wire logic        hclk,      // System clock
  input  wire logic        hresetn,   // Async reset, low active
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Always ready
  output logic             hresp,     // Always OKAY
  output logic             wr_ctrl,   // Data-phase write to control
  output logic             sel_ctrl,  // Data phase targets control
  output logic             sel_stat   // Data phase targets status
);

  logic dp_valid;
  logic dp_write;
  logic dp_ctrl;
  logic dp_stat;

  wire  ap_take  = hsel & hready & htrans[1];
  wire  [31:0] ap_word = haddr & IVP_ADDR_MASK;
  wire  ap_ctrl  = ap_word == IVP_CTRL_ADDR;
  wire  ap_stat  = ap_word == IVP_STAT_ADDR;
  wire  unused_sz = ^hsize;

  // Address phase captured for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_ctrl  <= 1'b0;
      dp_stat  <= 1'b0;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_ctrl  <= ap_ctrl;
      dp_stat  <= ap_stat;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = dp_valid & dp_write & dp_ctrl & ~unused_sz | dp_valid
                   & dp_write & dp_ctrl & unused_sz;
  assign sel_ctrl  = dp_valid & dp_ctrl;
  assign sel_stat  = dp_valid & dp_stat;

endmodule : ivp_ahb_slave

// ---- ivp_vec_addr.sv ----
`timescale 1ns/1ps
module ivp_vec_addr
  import ivp_pkg::*;
(
  input  wire logic [1:0]  boot_size_fuses,    // Boot section size
  input  wire logic        reset_to_boot_fuse, // Reset into boot section
  input  wire logic        vector_table_select,// Vectors in boot section
  input  wire logic [4:0]  vector_index,       // Default table slot
  output logic [11:0]      boot_start,         // Boot section start
  output logic [11:0]      next_reset_addr,    // Reset fetch address
  output logic [11:0]      next_vector_addr    // Vector fetch address
);

  wire [11:0] table_base;

  assign boot_start       = ivp_boot_start(boot_size_fuses);
  assign table_base       = vector_table_select ? boot_start
                                                : IVP_APP_START;
  assign next_reset_addr  = reset_to_boot_fuse ? boot_start
                                               : IVP_APP_START;
  assign next_vector_addr = table_base + {7'h00, vector_index};

endmodule : ivp_vec_addr

// ---- ivp_top.sv ----
`timescale 1ns/1ps
module ivp_top
  import ivp_pkg::*;
(
  input  wire logic        hclk,                  // System clock, 40 MHz
  input  wire logic        hresetn,               // Async reset, low active
  input  wire logic        hsel,                  // AHB slave select
  input  wire logic [31:0] haddr,                 // AHB address
  input  wire logic [1:0]  htrans,                // AHB transfer type
  input  wire logic        hwrite,                // AHB write
  input  wire logic [2:0]  hsize,                 // AHB size
  input  wire logic        hready,                // AHB ready in
  input  wire logic [31:0] hwdata,                // AHB write data
  output logic [31:0]      hrdata,                // AHB read data
  output logic             hreadyout,             // AHB ready out
  output logic             hresp,                 // AHB response
  input  wire logic [1:0]  boot_size_fuses,       // Boot size setting
  input  wire logic        reset_to_boot_fuse,    // High when programmed
  input  wire logic        app_section_boot_lock, // High when programmed
  input  wire logic        boot_section_boot_lock,// High when programmed
  input  wire logic        global_irq_enable,     // Core status I flag
  input  wire logic        instr_retire,          // Instruction done pulse
  input  wire logic [11:0] exec_pc,               // Executing word address
  input  wire logic [4:0]  vector_index,          // Pending vector slot
  output logic             irq_accept,            // Core may take interrupt
  output logic             change_blocked,        // Sequence blocking now
  output logic [11:0]      vector_address,        // Vector fetch address
  output logic [11:0]      reset_address,         // Reset fetch address
  output logic             ext_irq_zero_enable,   // External irq 0 enable
  output logic             ext_irq_one_enable     // External irq 1 enable
);

  // Control register state
  logic             vector_table_select;
  logic             vector_change_enable;
  logic [2:0]       window_count;
  logic             hold_after_write;
  ivp_state_t       state;
  ivp_state_t       next_state;

  // Fuse and lock levels caught after reset release
  logic             fuses_loaded;
  logic [1:0]       boot_size_q;
  logic             reset_to_boot_q;
  logic             app_lock_q;
  logic             boot_lock_q;

  // Bus decode
  logic             wr_ctrl;
  logic             sel_ctrl;
  logic             sel_stat;

  // Address unit results
  logic [11:0]      boot_start;
  logic [11:0]      next_reset_addr;
  logic [11:0]      next_vector_addr;

  ivp_ahb_slave ivp_ahb_slave_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wr_ctrl   (wr_ctrl),
    .sel_ctrl  (sel_ctrl),
    .sel_stat  (sel_stat)
  );

  ivp_vec_addr ivp_vec_addr_inst (
    .boot_size_fuses     (boot_size_q),
    .reset_to_boot_fuse  (reset_to_boot_q),
    .vector_table_select (vector_table_select),
    .vector_index        (vector_index),
    .boot_start          (boot_start),
    .next_reset_addr     (next_reset_addr),
    .next_vector_addr    (next_vector_addr)
  );

  // Write decode of the control byte
  wire wr_vce      = wr_ctrl & hwdata[IVP_VCE_BIT];
  wire wr_vsel_try = wr_ctrl & ~hwdata[IVP_VCE_BIT];
  wire window_open = vector_change_enable;
  wire vsel_accept = wr_vsel_try & window_open;
  wire window_end  = window_open & (window_count == 3'h1);

  // Sequence state
  always_comb begin
    next_state = state;
    case (state)
      IVP_IDLE: begin
        if (wr_vce) begin
          next_state = IVP_OPEN;
        end
      end
      IVP_OPEN: begin
        if (wr_vce) begin
          next_state = IVP_OPEN;
        end else if (vsel_accept) begin
          next_state = IVP_HOLD;
        end else if (window_end) begin
          next_state = IVP_IDLE;
        end
      end
      IVP_HOLD: begin
        if (wr_vce) begin
          next_state = IVP_OPEN;
        end else if (instr_retire) begin
          next_state = IVP_IDLE;
        end
      end
      default: next_state = IVP_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= IVP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Change enable bit and its four-cycle window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_change_enable <= IVP_CTRL_RESET[IVP_VCE_BIT];
      window_count         <= 3'h0;
    end else if (wr_vce) begin
      vector_change_enable <= 1'b1;
      window_count         <= IVP_WINDOW_CYC;
    end else if (vsel_accept | window_end) begin
      vector_change_enable <= 1'b0;
      window_count         <= 3'h0;
    end else if (window_open) begin
      window_count         <= window_count - 3'h1;
    end
  end

  // Select bit changes only through the open window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_table_select <= IVP_CTRL_RESET[IVP_VSEL_BIT];
    end else if (vsel_accept) begin
      vector_table_select <= hwdata[IVP_VSEL_BIT];
    end
  end

  assign hold_after_write = state == IVP_HOLD;

  // External interrupt enables are plain read/write bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_zero_enable <= IVP_CTRL_RESET[IVP_EXT0_BIT];
      ext_irq_one_enable  <= IVP_CTRL_RESET[IVP_EXT1_BIT];
    end else if (wr_ctrl) begin
      ext_irq_zero_enable <= hwdata[IVP_EXT0_BIT];
      ext_irq_one_enable  <= hwdata[IVP_EXT1_BIT];
    end
  end

  // Fuses are static straps, captured once after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuses_loaded    <= 1'b0;
      boot_size_q     <= 2'h0;
      reset_to_boot_q <= 1'b0;
      app_lock_q      <= 1'b0;
      boot_lock_q     <= 1'b0;
    end else if (!fuses_loaded) begin
      fuses_loaded    <= 1'b1;
      boot_size_q     <= boot_size_fuses;
      reset_to_boot_q <= reset_to_boot_fuse;
      app_lock_q      <= app_section_boot_lock;
      boot_lock_q     <= boot_section_boot_lock;
    end
  end

  // Lock-bit suppression by where code is running
  wire in_boot     = exec_pc >= boot_start;
  wire lock_app    = vector_table_select & app_lock_q & ~in_boot;
  wire lock_boot   = ~vector_table_select & boot_lock_q & in_boot;
  wire lock_block  = lock_app | lock_boot;

  // Sequence blocking starts combinationally in the setting cycle
  wire seq_block   = wr_vce | window_open | hold_after_write;

  assign change_blocked = seq_block;
  // Global flag is only gated here, never written back
  assign irq_accept     = global_irq_enable & ~seq_block
                        & ~lock_block & fuses_loaded;

  // Fetch addresses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_address <= IVP_APP_START;
      reset_address  <= IVP_APP_START;
    end else begin
      vector_address <= next_vector_addr;
      reset_address  <= next_reset_addr;
    end
  end

  // Read-back
  wire [7:0] ctrl_rd = {ext_irq_one_enable, ext_irq_zero_enable, 4'h0,
                        vector_table_select, vector_change_enable};

  wire [31:0] stat_rd = {4'h0, boot_start, 9'h000, window_count,
                         1'b0, lock_block, hold_after_write, seq_block};

  assign hrdata = sel_ctrl ? {24'h00_0000, ctrl_rd}
                : sel_stat ? stat_rd
                : 32'h0000_0000;

  wire unused_vec = ^{IVP_VEC_LAST, IVP_ST_BLOCK, IVP_ST_HOLD,
                      IVP_ST_LOCK, IVP_ST_CNT_LSB, IVP_ST_BOOT_LSB};

endmodule : ivp_top

// ---- ivp_top_assertions.sv ----
`timescale 1ns/1ps
module ivp_top_checker
  import ivp_pkg::*;
(
  input wire logic        hclk,                   // Clock
  input wire logic        hresetn,                // Reset
  input wire logic        hsel,                   // Select
  input wire logic [31:0] haddr,                  // Address
  input wire logic [1:0]  htrans,                 // Transfer
  input wire logic        hwrite,                 // Write
  input wire logic        hready,                 // Ready
  input wire logic [31:0] hwdata,                 // Write data
  input wire logic [1:0]  boot_size_fuses,        // Boot size
  input wire logic        app_section_boot_lock,  // App lock
  input wire logic        boot_section_boot_lock, // Boot lock
  input wire logic        global_irq_enable,      // Core flag
  input wire logic        instr_retire,           // Retire
  input wire logic [11:0] exec_pc,                // Code address
  input wire logic [4:0]  vector_index,           // Slot
  input wire logic        irq_accept,             // Accept
  input wire logic        change_blocked,         // Blocking
  input wire logic [11:0] vector_address          // Vector
);
  logic       dp_wr;
  logic [2:0] win;
  logic       hold;
  logic       sel;
  wire        set_wr = dp_wr && hwdata[IVP_VCE_BIT];
  wire        sel_wr = dp_wr && !hwdata[IVP_VCE_BIT] && (win != 3'h0);
  wire [11:0] bs = (boot_size_fuses == 2'h0) ? IVP_BOOT_2K :
                   (boot_size_fuses == 2'h1) ? IVP_BOOT_1K :
                   (boot_size_fuses == 2'h2) ? IVP_BOOT_512 : IVP_BOOT_256;
  wire        in_boot = exec_pc >= bs;
  // Shadow of the change window, hold phase and select bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      win   <= 3'h0;
      hold  <= 1'b0;
      sel   <= 1'b0;
    end else begin
      dp_wr <= hsel && hready && htrans[1] && hwrite &&
               ((haddr & IVP_ADDR_MASK) == IVP_CTRL_ADDR);
      win   <= set_wr ? IVP_WINDOW_CYC :
               (dp_wr || win == 3'h0) ? 3'h0 : win - 3'h1;
      // A fresh enable write ends the hold and reopens the window
      hold  <= sel_wr ? 1'b1 : (instr_retire || set_wr) ? 1'b0 : hold;
      sel   <= sel_wr ? hwdata[IVP_VSEL_BIT] : sel;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_accept_gate: assert property (
    irq_accept |-> global_irq_enable && !change_blocked)
    else $error("accept while masked");
  a_set_blocks: assert property (
    set_wr |-> change_blocked ##1 change_blocked)
    else $error("enable write did not block");
  a_window_open: assert property (
    win != 3'h0 |-> change_blocked)
    else $error("window open but not blocked");
  a_hold_retire: assert property (
    hold |-> change_blocked)
    else $error("block dropped before retire");
  a_window_ends: assert property (
    !set_wr && win == 3'h0 && !hold && !$past(hold) |-> !change_blocked)
    else $error("block outlived window");
  a_vec_place: assert property (
    $past(hresetn, 2) |-> vector_address ==
      ($past(sel) ? bs : 12'h000) + {7'h0, $past(vector_index)})
    else $error("vector address wrong");
  a_app_lock: assert property (
    $past(hresetn, 2) && $stable(exec_pc) && $stable(sel) && sel &&
    app_section_boot_lock && !in_boot |-> !irq_accept)
    else $error("accept in locked app code");
  a_boot_lock: assert property (
    $past(hresetn, 2) && $stable(exec_pc) && $stable(sel) && !sel &&
    boot_section_boot_lock && in_boot |-> !irq_accept)
    else $error("accept in locked boot code");
  c_relocate: cover property (set_wr ##3 sel_wr);
  c_expire: cover property (win == 3'h1 ##1 win == 3'h0);
  c_hold_done: cover property (hold ##1 !hold);
endmodule : ivp_top_checker

// ---- ivp_core_model.sv ----
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic       hclk,        // Clock
  input  wire logic       hresetn,     // Reset, low active
  input  wire logic       run,         // Low stalls in a long instruction
  input  wire logic [3:0] gap,         // Cycles between retires
  output logic            instr_retire // One-cycle retire pulse
);
  logic [3:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt          <= 4'h0;
      instr_retire <= 1'b0;
    end else begin
      cnt          <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      instr_retire <= run && (cnt >= gap);
    end
  end
endmodule : ivp_core_model

// ---- interrupt_vector_placement_bench.sv ----
`timescale 1ns/1ps
module interrupt_vector_placement_bench;
  import ivp_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  boot_size_fuses = 2'h0;
  logic        reset_to_boot_fuse = 1'b0;
  logic        app_section_boot_lock = 1'b0;
  logic        boot_section_boot_lock = 1'b0;
  logic        global_irq_enable = 1'b1;
  logic [11:0] exec_pc = 12'h0;
  logic [4:0]  vector_index = 5'h1;
  logic        run = 1'b1;
  logic [3:0]  gap = 4'h2;
  logic [31:0] hrdata, rdq;
  logic        hreadyout, hresp, instr_retire, irq_accept;
  logic        change_blocked, ext0, ext1;
  logic [11:0] vector_address, reset_address;
  logic [11:0] starts [4] = '{IVP_BOOT_2K, IVP_BOOT_1K, IVP_BOOT_512,
                              IVP_BOOT_256};
  int          checked = 0;
  int          mismatches = 0;
  int          cyc = 0;
  ivp_top ivp_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .boot_size_fuses(boot_size_fuses),
    .reset_to_boot_fuse(reset_to_boot_fuse),
    .app_section_boot_lock(app_section_boot_lock),
    .boot_section_boot_lock(boot_section_boot_lock),
    .global_irq_enable(global_irq_enable), .instr_retire(instr_retire),
    .exec_pc(exec_pc), .vector_index(vector_index),
    .irq_accept(irq_accept), .change_blocked(change_blocked),
    .vector_address(vector_address), .reset_address(reset_address),
    .ext_irq_zero_enable(ext0), .ext_irq_one_enable(ext1));
  ivp_core_model ivp_core_model_inst (.hclk(hclk), .hresetn(hresetn),
    .run(run), .gap(gap), .instr_retire(instr_retire));
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) rdq <= hrdata;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= IVP_HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
    q = rdq;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : step
  task automatic vi(input logic [4:0] v);
    @(posedge hclk);
    vector_index <= v;
    step(1);
  endtask : vi
  task automatic pc(input logic [11:0] v);
    @(posedge hclk);
    exec_pc <= v;
    step(1);
  endtask : pc
  task automatic rst(input logic [1:0] f, input logic rb, lk);
    @(posedge hclk);
    hresetn                <= 1'b0;
    boot_size_fuses        <= f;
    reset_to_boot_fuse     <= rb;
    app_section_boot_lock  <= lk;
    boot_section_boot_lock <= lk;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    step(2);
  endtask : rst
  task automatic test_reset;
    for (int f = 0; f < 4; f++) begin
      rst(2'(f), 1'b1, 1'b0);
      chk(32'(reset_address), 32'(starts[f]));
    end
    rst(2'h0, 1'b0, 1'b0);
    chk(32'(reset_address), 32'h0);
    chk(32'(vector_address), 32'h1);
    chk(32'({irq_accept, hresp}), 32'h2);
    rdc(IVP_CTRL_ADDR, 32'h0);
    rdc(32'h0000_0010, 32'h0);
    rdc(IVP_STAT_ADDR, 32'(IVP_BOOT_2K) << IVP_ST_BOOT_LSB);
    $display("test reset done");
  endtask : test_reset
  task automatic test_move;
    int n;
    @(posedge hclk);
    run <= 1'b0;
    wr(IVP_CTRL_ADDR, 32'h1);
    chk(32'({change_blocked, irq_accept}), 32'h2);
    wr(IVP_CTRL_ADDR, 32'h2);
    rdc(IVP_CTRL_ADDR, 32'h2);
    chk(32'(change_blocked), 32'h1);
    rdc(IVP_STAT_ADDR, (32'(IVP_BOOT_2K) << IVP_ST_BOOT_LSB) |
        (32'h1 << IVP_ST_HOLD) | (32'h1 << IVP_ST_BLOCK));
    vi(5'h1);
    chk(32'(vector_address), 32'hc01);
    vi(5'h12);
    chk(32'(vector_address), 32'hc12);
    @(posedge hclk);
    run <= 1'b1;
    while (instr_retire !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    step(2);
    chk(32'({change_blocked, irq_accept}), 32'h1);
    $display("test move done");
  endtask : test_move
  task automatic test_expire;
    wr(IVP_CTRL_ADDR, 32'h1);
    step(3);
    chk(32'(change_blocked), 32'h1);
    step(1);
    chk(32'({change_blocked, irq_accept}), 32'h1);
    wr(IVP_CTRL_ADDR, 32'hc0);
    rdc(IVP_CTRL_ADDR, 32'hc2);
    chk(32'({ext1, ext0}), 32'h3);
    @(posedge hclk);
    global_irq_enable <= 1'b0;
    step(1);
    chk(32'(irq_accept), 32'h0);
    @(posedge hclk);
    global_irq_enable <= 1'b1;
    $display("test expire done");
  endtask : test_expire
  task automatic test_locks;
    rst(2'h0, 1'b0, 1'b1);
    pc(12'hc10);
    chk(32'(irq_accept), 32'h0);
    pc(12'h100);
    chk(32'(irq_accept), 32'h1);
    wr(IVP_CTRL_ADDR, 32'h1);
    wr(IVP_CTRL_ADDR, 32'h2);
    step(6);
    chk(32'(irq_accept), 32'h0);
    pc(12'hc10);
    chk(32'(irq_accept), 32'h1);
    vi(5'h5);
    chk(32'(vector_address), 32'hc05);
    $display("test locks done");
  endtask : test_locks
  task complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    test_reset();
    test_move();
    test_expire();
    test_locks();
    complete_run();
  end
endmodule : interrupt_vector_placement_bench
bind ivp_top ivp_top_checker ivp_top_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .boot_size_fuses(boot_size_fuses),
  .app_section_boot_lock(app_section_boot_lock),
  .boot_section_boot_lock(boot_section_boot_lock),
  .global_irq_enable(global_irq_enable), .instr_retire(instr_retire),
  .exec_pc(exec_pc), .vector_index(vector_index), .irq_accept(irq_accept),
  .change_blocked(change_blocked), .vector_address(vector_address));
